// [hdl/eya_alarm_monitor.sv]
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
// Summary of operation
// - frame remote alarm change requests interrupt only when enable bit 0 is set
// - block enable bit 1 gates every alarm interrupt with the per-alarm enable
// - frame remote alarm change, enables set, sets status bit 0
// - a set change bit stays until the host clears it, by read or by write depending on the clear mode
// - clear-on-read clears status on read; otherwise host writes ones to clear
// - each 4 ms interval is flagged if the multiframe pattern appeared once
// - flagged multiframe intervals count up; alarm declared at 80
// - unflagged multiframe intervals count down; alarm withdrawn at zero
// - multiframe alarm change requests interrupt only when enable bit 5 is set
// - multiframe alarm change, enables set, sets its change status bit
// - frame pattern checked per interval, counted up, alarm declared at 80
// - unflagged frame intervals count down; alarm withdrawn at zero
// - status bit 5 reports multiframe change, cleared on read or write
module eya_alarm_monitor (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_frame_sync,
	input wire logic i_frame_remote_alarm,
	input wire logic i_multiframe_remote_alarm,
	output logic [7:0] o_rdata,
	output logic o_irq,
	output logic o_frame_remote_alarm,
	output logic o_multiframe_remote_alarm
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// address match shared by read and write paths
	function automatic logic eya_hit(input eya_pkg::eya_req_t rq, input logic [7:0] off);
		eya_hit = (rq.addr == off);
	endfunction

	// up/down step that never wraps
	function automatic logic [6:0] eya_step(input logic [6:0] cnt, input logic flagged);
		if (flagged) begin
			eya_step = (cnt == eya_pkg::DECLARE_COUNT) ? cnt : cnt + 7'h01;
		end else begin
			eya_step = (cnt == eya_pkg::COUNT_ZERO) ? cnt : cnt - 7'h01;
		end
	endfunction

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	eya_pkg::eya_req_t req;
	logic [1:0] pattern;
	logic [4:0] frame_cnt_ff;
	logic iv_end;
	logic [1:0] flag_ff;
	logic [1:0] flagged;
	logic [6:0] cnt_ff [2];
	logic [6:0] nxt_cnt [2];
	eya_pkg::eya_alm_t alm_ff [2];
	logic [1:0] alarm_now;
	logic [1:0] chg;
	logic [7:0] blk_int_en_ff;
	logic [7:0] alm_int_en_ff;
	logic [7:0] int_ctrl_ff;
	logic [7:0] status_ff;
	logic [7:0] nxt_status;
	logic [7:0] nxt_rdata;
	logic read_clear;
	logic write_clear;
	logic [7:0] pending;

	assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
	assign pattern = {i_multiframe_remote_alarm, i_frame_remote_alarm};

	// ---------------------------------------------------------------
	// interval timing
	// ---------------------------------------------------------------
	// the interval follows received frames, so it stretches with line slips
	assign iv_end = i_frame_sync && (frame_cnt_ff == eya_pkg::FRAME_CNT_LAST);

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			frame_cnt_ff <= 5'h00;
		end else if (i_ce && i_frame_sync) begin
			frame_cnt_ff <= iv_end ? 5'h00 : frame_cnt_ff + 5'h01;
		end
	end

	// pattern seen in the closing cycle still counts for the closing interval
	assign flagged = flag_ff | pattern;

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			flag_ff <= 2'b00;
		end else if (i_ce) begin
			flag_ff <= iv_end ? 2'b00 : flagged;
		end
	end

	// ---------------------------------------------------------------
	// flag counters and alarm state
	// ---------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			nxt_cnt[i] = eya_step(cnt_ff[i], flagged[i]);
			alarm_now[i] = (alm_ff[i] == eya_pkg::ALM_DECLARED);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			cnt_ff[0] <= eya_pkg::COUNT_ZERO;
			cnt_ff[1] <= eya_pkg::COUNT_ZERO;
		end else if (i_ce && iv_end) begin
			cnt_ff[0] <= nxt_cnt[0];
			cnt_ff[1] <= nxt_cnt[1];
		end
	end

	// change pulse: declare or withdraw, one cycle, at interval close
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			chg[i] = 1'b0;
			if (iv_end) begin
				case (alm_ff[i])
					eya_pkg::ALM_CLEAR: chg[i] = (nxt_cnt[i] == eya_pkg::DECLARE_COUNT);
					eya_pkg::ALM_DECLARED: chg[i] = (nxt_cnt[i] == eya_pkg::COUNT_ZERO);
					default: chg[i] = 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			alm_ff[0] <= eya_pkg::ALM_CLEAR;
			alm_ff[1] <= eya_pkg::ALM_CLEAR;
		end else if (i_ce) begin
			for (int i = 0; i < 2; i++) begin
				if (chg[i]) begin
					// any illegal code also falls back to clear
					if (alm_ff[i] == eya_pkg::ALM_CLEAR) begin
						alm_ff[i] <= eya_pkg::ALM_DECLARED;
					end else begin
						alm_ff[i] <= eya_pkg::ALM_CLEAR;
					end
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// enable and control registers
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			blk_int_en_ff <= eya_pkg::BLOCK_INT_ENABLE_RST;
			alm_int_en_ff <= eya_pkg::ALARM_ERROR_INT_ENABLE_RST;
			int_ctrl_ff <= eya_pkg::INTERRUPT_CONTROL_RST;
		end else if (i_ce && req.wr) begin
			if (eya_hit(req, eya_pkg::BLOCK_INT_ENABLE_OFF)) begin
				blk_int_en_ff <= req.wdata;
			end
			if (eya_hit(req, eya_pkg::ALARM_ERROR_INT_ENABLE_OFF)) begin
				alm_int_en_ff <= req.wdata;
			end
			if (eya_hit(req, eya_pkg::INTERRUPT_CONTROL_OFF)) begin
				int_ctrl_ff <= req.wdata;
			end
		end
	end

	// ---------------------------------------------------------------
	// change status with set-over-clear
	// ---------------------------------------------------------------
	assign read_clear = req.rd && int_ctrl_ff[eya_pkg::CLEAR_ON_READ_BIT]
		&& (eya_hit(req, eya_pkg::ALARM_ERROR_STATUS_OFF)
		|| eya_hit(req, eya_pkg::FRAMER_INT_STATUS_OFF));
	assign write_clear = req.wr && !int_ctrl_ff[eya_pkg::CLEAR_ON_READ_BIT]
		&& eya_hit(req, eya_pkg::ALARM_ERROR_STATUS_OFF);

	always_comb begin
		nxt_status = status_ff;
		if (read_clear) begin
			nxt_status = 8'h00;
		end
		if (write_clear) begin
			nxt_status = status_ff & ~req.wdata;
		end
		// status only records changes while both enables are on
		if (chg[0] && alm_int_en_ff[eya_pkg::FRAME_ALARM_BIT]
			&& blk_int_en_ff[eya_pkg::ALARM_GROUP_EN_BIT]) begin
			nxt_status[eya_pkg::FRAME_ALARM_BIT] = 1'b1;
		end
		if (chg[1] && alm_int_en_ff[eya_pkg::MULTI_ALARM_BIT]
			&& blk_int_en_ff[eya_pkg::ALARM_GROUP_EN_BIT]) begin
			nxt_status[eya_pkg::MULTI_ALARM_BIT] = 1'b1;
		end
		// unimplemented change bits stay zero
		nxt_status = nxt_status & ((8'h01 << eya_pkg::FRAME_ALARM_BIT)
			| (8'h01 << eya_pkg::MULTI_ALARM_BIT));
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			status_ff <= eya_pkg::ALARM_ERROR_STATUS_RST;
		end else if (i_ce) begin
			status_ff <= nxt_status;
		end
	end

	// ---------------------------------------------------------------
	// interrupt and read data
	// ---------------------------------------------------------------
	assign pending = status_ff & alm_int_en_ff
		& {8{blk_int_en_ff[eya_pkg::ALARM_GROUP_EN_BIT]}};

	always_comb begin
		nxt_rdata = 8'h00; // unmapped offsets read zero
		case (1'b1)
			eya_hit(req, eya_pkg::FRAMER_INT_STATUS_OFF): begin
				nxt_rdata[eya_pkg::ALARM_GROUP_PEND_BIT] = |pending;
			end
			eya_hit(req, eya_pkg::BLOCK_INT_ENABLE_OFF): nxt_rdata = blk_int_en_ff;
			eya_hit(req, eya_pkg::ALARM_ERROR_STATUS_OFF): nxt_rdata = status_ff;
			eya_hit(req, eya_pkg::ALARM_ERROR_INT_ENABLE_OFF): nxt_rdata = alm_int_en_ff;
			eya_hit(req, eya_pkg::INTERRUPT_CONTROL_OFF): nxt_rdata = int_ctrl_ff;
			eya_hit(req, eya_pkg::ALARM_STATE_OFF): begin
				nxt_rdata[eya_pkg::FRAME_ALARM_BIT] = alarm_now[0];
				nxt_rdata[eya_pkg::MULTI_ALARM_BIT] = alarm_now[1];
			end
			default: nxt_rdata = 8'h00;
		endcase
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_rdata <= eya_pkg::READ_DATA_RST;
		end else if (i_ce) begin
			o_rdata <= req.rd ? nxt_rdata : eya_pkg::READ_DATA_RST;
		end
	end

	// one cycle behind status; acceptable for a level interrupt
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_irq <= 1'b0;
			o_frame_remote_alarm <= 1'b0;
			o_multiframe_remote_alarm <= 1'b0;
		end else if (i_ce) begin
			o_irq <= |pending;
			o_frame_remote_alarm <= alarm_now[0];
			o_multiframe_remote_alarm <= alarm_now[1];
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	sequence s_multi_seen;
		i_ce && pattern[1] && !iv_end;
	endsequence

	sequence s_status_read;
		i_ce && req.rd && eya_hit(req, eya_pkg::ALARM_ERROR_STATUS_OFF);
	endsequence

	AST_FRAME_EN_OFF: assert property (i_ce && !alm_int_en_ff[0] && !status_ff[0]
		|=> !status_ff[0])
		else $error("frame change bit set while its enable is off");
	AST_BLOCK_GATE: assert property (i_ce && !blk_int_en_ff[1] |=> !o_irq)
		else $error("interrupt raised with block enable off");
	// an enable write in the set cycle may legally drop the interrupt, so it is left out
	AST_FRAME_SET: assert property (i_ce && !req.wr && chg[0] && alm_int_en_ff[0]
		&& blk_int_en_ff[1] |=> status_ff[0] ##1 (o_irq || !i_ce))
		else $error("frame change did not set status and interrupt");
	AST_STICKY: assert property (i_ce && status_ff[0] && !read_clear
		&& !(write_clear && req.wdata[0]) |=> status_ff[0])
		else $error("change bit dropped without a clear");
	AST_CLEAR_ON_READ: assert property (s_status_read ##0 (int_ctrl_ff[0] && !chg[0])
		|=> !status_ff[0])
		else $error("read did not clear status");
	AST_MULTI_FLAG: assert property (s_multi_seen |=> flag_ff[1])
		else $error("multiframe pattern not flagged");
	AST_MULTI_DECLARE: assert property (i_ce && iv_end && cnt_ff[1] == 7'h4F
		&& flagged[1] |=> alarm_now[1] ##1 (o_multiframe_remote_alarm || !i_ce))
		else $error("multiframe alarm not declared at threshold");
	AST_MULTI_WITHDRAW: assert property (i_ce && iv_end && cnt_ff[1] == 7'h01
		&& !flagged[1] |=> !alarm_now[1])
		else $error("multiframe alarm not withdrawn at zero");
	AST_MULTI_EN_OFF: assert property (i_ce && !alm_int_en_ff[5] && !status_ff[5]
		|=> !status_ff[5])
		else $error("multiframe change bit set while its enable is off");
	AST_MULTI_SET: assert property (i_ce && chg[1] && alm_int_en_ff[5]
		&& blk_int_en_ff[1] |=> status_ff[5])
		else $error("multiframe change did not set status");
	AST_FRAME_DECLARE: assert property (i_ce && iv_end && cnt_ff[0] == 7'h4F
		&& flagged[0] |=> alarm_now[0])
		else $error("frame alarm not declared at threshold");
	AST_FRAME_WITHDRAW: assert property (i_ce && iv_end && cnt_ff[0] == 7'h01
		&& !flagged[0] |=> !alarm_now[0])
		else $error("frame alarm not withdrawn at zero");
	AST_STATUS_READBACK: assert property (s_status_read
		|=> o_rdata[5] == $past(status_ff[5]))
		else $error("status bit 5 read back wrong");
	AST_SATURATE: assert property (cnt_ff[0] <= 7'h50 && cnt_ff[1] <= 7'h50)
		else $error("interval counter passed its threshold");
	// alarm state may only move when an interval closes
	AST_CHANGE_AT_END: assert property (i_ce && !iv_end
		|=> alarm_now == $past(alarm_now))
		else $error("alarm change outside interval close");

endmodule

// [hdl/eya_pkg.sv]
package eya_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [7:0] FRAMER_INT_STATUS_OFF = 8'h00;
	localparam logic [7:0] BLOCK_INT_ENABLE_OFF = 8'h01;
	localparam logic [7:0] ALARM_ERROR_STATUS_OFF = 8'h02;
	localparam logic [7:0] ALARM_ERROR_INT_ENABLE_OFF = 8'h03;
	localparam logic [7:0] INTERRUPT_CONTROL_OFF = 8'h04;
	localparam logic [7:0] ALARM_STATE_OFF = 8'h05;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int FRAME_ALARM_BIT = 0;
	localparam int MULTI_ALARM_BIT = 5;
	localparam int ALARM_GROUP_EN_BIT = 1;
	localparam int ALARM_GROUP_PEND_BIT = 1;
	localparam int CLEAR_ON_READ_BIT = 0;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] BLOCK_INT_ENABLE_RST = 8'h00;
	localparam logic [7:0] ALARM_ERROR_INT_ENABLE_RST = 8'h00;
	localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00;
	localparam logic [7:0] ALARM_ERROR_STATUS_RST = 8'h00;
	localparam logic [7:0] READ_DATA_RST = 8'h00;

	// ---------------------------------------------------------------
	// timing: interval measured in received frames
	// ---------------------------------------------------------------
	localparam int INTERVAL_NS = 4000000;
	localparam int FRAME_NS = 125000;
	localparam int FRAMES_PER_INTERVAL = INTERVAL_NS / FRAME_NS;
	localparam logic [4:0] FRAME_CNT_LAST = 5'(FRAMES_PER_INTERVAL - 1);
	localparam logic [6:0] DECLARE_COUNT = 7'h50;
	localparam logic [6:0] COUNT_ZERO = 7'h00;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} eya_req_t;

	typedef enum logic [1:0] {
		ALM_CLEAR = 2'b01,
		ALM_DECLARED = 2'b10
	} eya_alm_t;

endpackage

// [verification/eya_host_model.sv]
`timescale 1ns/100ps
// ---------------------------------------------------------------
// host processor on the register port
// ---------------------------------------------------------------
module eya_host_model (
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	// bus parked idle from time zero so no strobe is ever unknown
	initial begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end

	// one-cycle write; an idle edge always follows before the next strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so take them
	// at the edge that closes that cycle, before it updates o_rdata
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		@(posedge i_clk);
		d = i_rdata;
	endtask

	// write ones to clear change bits; useless once clear-on-read is on
	task automatic clear_status(input logic [7:0] bits);
		wr(eya_pkg::ALARM_ERROR_STATUS_OFF, bits);
	endtask
endmodule

// [verification/e1_yellow_alarm_monitor_tb_top.sv]
`timescale 1ns/100ps
module e1_yellow_alarm_monitor_tb_top;
	logic clk;
	logic rstn;
	logic ce;
	logic sync;
	logic fr;
	logic mf;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic wr;
	logic rd;
	logic irq;
	logic fr_alm;
	logic mf_alm;
	logic [7:0] d;
	int fail_count;
	int checked;
	int cycles = 0;

	// ---------------------------------------------------------------
	// clock, design and host
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	eya_alarm_monitor i_dut (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_frame_sync(sync),
		.i_frame_remote_alarm(fr), .i_multiframe_remote_alarm(mf), .o_rdata(rdata),
		.o_irq(irq), .o_frame_remote_alarm(fr_alm), .o_multiframe_remote_alarm(mf_alm));

	eya_host_model i_host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
		.o_wr(wr), .o_rd(rd));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		i_host.rd(a, d);
		chk(d, exp);
	endtask

	// frame pattern only in the closing cycle, so a single sighting must flag;
	// multiframe pattern held through the whole interval
	task automatic run(input int n, input logic f, input logic m);
		for (int i = 0; i < n * 32; i++) begin
			@(posedge clk);
			sync <= 1'b1;
			fr <= f && (i % 32 == 31);
			mf <= m;
		end
		@(posedge clk);
		sync <= 1'b0;
		fr <= 1'b0;
		mf <= 1'b0;
	endtask

	// state one edge after close, outputs and irq one more
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask

	// hang guard: whole run is about 16000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles >= 20000) begin
			fail_count++;
			final_report();
		end
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		sync = 1'b0;
		fr = 1'b0;
		mf = 1'b0;
		fail_count = 0;
		checked = 0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		// reset values, unmapped offset, read data one cycle only
		for (int a = 0; a < 6; a++) begin
			rchk(8'(a), 8'h00);
		end
		i_host.wr(8'h10, 8'hFF);
		rchk(8'h10, 8'h00);
		i_host.wr(eya_pkg::BLOCK_INT_ENABLE_OFF, 8'h02);
		i_host.wr(eya_pkg::ALARM_ERROR_INT_ENABLE_OFF, 8'h21);
		rchk(eya_pkg::BLOCK_INT_ENABLE_OFF, 8'h02);
		#1;
		chk(rdata, 8'h00);
		rchk(eya_pkg::ALARM_ERROR_INT_ENABLE_OFF, 8'h21);
		// clock enable low freezes the registers, so this write is lost
		ce <= 1'b0;
		i_host.wr(eya_pkg::BLOCK_INT_ENABLE_OFF, 8'h00);
		ce <= 1'b1;
		rchk(eya_pkg::BLOCK_INT_ENABLE_OFF, 8'h02);
		// multiframe: 79 flagged intervals are not enough, the 80th declares
		run(79, 1'b0, 1'b1);
		settle();
		chk({7'h00, mf_alm}, 8'h00);
		rchk(eya_pkg::ALARM_ERROR_STATUS_OFF, 8'h00);
		run(1, 1'b0, 1'b1);
		settle();
		chk({6'h00, mf_alm, irq}, 8'h03);
		rchk(eya_pkg::ALARM_ERROR_STATUS_OFF, 8'h20);
		rchk(eya_pkg::ALARM_ERROR_STATUS_OFF, 8'h20);
		rchk(eya_pkg::ALARM_STATE_OFF, 8'h20);
		rchk(eya_pkg::FRAMER_INT_STATUS_OFF, 8'h02);
		i_host.clear_status(8'h20);
		settle();
		chk({7'h00, irq}, 8'h00);
		rchk(eya_pkg::ALARM_ERROR_STATUS_OFF, 8'h00);
		// saturated at 80: one extra flagged, then exactly 80 unflagged withdraw
		run(1, 1'b0, 1'b1);
		run(79, 1'b0, 1'b0);
		settle();
		chk({7'h00, mf_alm}, 8'h01);
		run(1, 1'b0, 1'b0);
		settle();
		chk({6'h00, mf_alm, irq}, 8'h01);
		// clear on read
		i_host.wr(eya_pkg::INTERRUPT_CONTROL_OFF, 8'h01);
		rchk(eya_pkg::ALARM_ERROR_STATUS_OFF, 8'h20);
		rchk(eya_pkg::ALARM_ERROR_STATUS_OFF, 8'h00);
		chk({7'h00, irq}, 8'h00);
		// frame alarm with block enable off: state moves, nothing recorded
		i_host.wr(eya_pkg::BLOCK_INT_ENABLE_OFF, 8'h00);
		i_host.wr(eya_pkg::ALARM_ERROR_INT_ENABLE_OFF, 8'h01);
		run(80, 1'b1, 1'b0);
		settle();
		chk({6'h00, fr_alm, irq}, 8'h02);
		rchk(eya_pkg::ALARM_ERROR_STATUS_OFF, 8'h00);
		i_host.wr(eya_pkg::BLOCK_INT_ENABLE_OFF, 8'h02);
		run(80, 1'b0, 1'b0);
		settle();
		chk({6'h00, fr_alm, irq}, 8'h01);
		rchk(eya_pkg::ALARM_ERROR_STATUS_OFF, 8'h01);
		rchk(eya_pkg::FRAMER_INT_STATUS_OFF, 8'h00);
		// multiframe enable bit off: state moves, no status bit and no interrupt
		run(80, 1'b0, 1'b1);
		settle();
		chk({6'h00, mf_alm, irq}, 8'h02);
		rchk(eya_pkg::ALARM_ERROR_STATUS_OFF, 8'h00);
		// late enable recalls nothing; a write cannot clear under clear-on-read
		i_host.wr(eya_pkg::ALARM_ERROR_INT_ENABLE_OFF, 8'h21);
		rchk(eya_pkg::ALARM_ERROR_STATUS_OFF, 8'h00);
		run(80, 1'b0, 1'b0);
		settle();
		chk({6'h00, mf_alm, irq}, 8'h01);
		i_host.clear_status(8'h20);
		rchk(eya_pkg::FRAMER_INT_STATUS_OFF, 8'h02);
		rchk(eya_pkg::ALARM_ERROR_STATUS_OFF, 8'h00);
		chk({7'h00, irq}, 8'h00);
		final_report();
	end
endmodule
